/* File: rtl/pnc_mdio_engine.sv */
/*
 * Management frame engine: walks preamble, start, header, turnaround
 * and data, issues one-cycle register access requests and shifts read
 * data out. Assumes mdc_rise and mdio_bit come already synchronised.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pnc_regs.svh"

module pnc_mdio_engine
	import pnc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        mdc_rise,
	input  wire logic        mdio_bit,
	input  wire logic [15:0] rd_data,
	output var  pnc_acc_t    acc,
	output var  logic        mdio_out,
	output var  logic        mdio_oe
);

	pnc_mdio_state_t state_reg;
	logic [5:0]      pre_cnt_reg;
	logic [4:0]      bit_cnt_reg;
	logic [10:0]     hdr_reg;
	logic [15:0]     sh_reg;
	logic            reading_reg;
	logic            writing_reg;

	// ****************************************************************
	// Header decode
	// ****************************************************************
	wire logic [11:0] hdr_full = {hdr_reg, mdio_bit};
	wire logic [4:0]  phy_base = `PNC_PHY_BASE;
	wire logic        phy_hit  = (hdr_full[9:6] == phy_base[4:1]);
	wire logic        op_rd    = (hdr_full[11:10] == 2'b10);
	wire logic        op_wr    = (hdr_full[11:10] == 2'b01);
	wire logic        bit_last = (bit_cnt_reg == `PNC_DATA_LAST);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg   <= MDIO_IDLE;
			pre_cnt_reg <= 6'h00;
			bit_cnt_reg <= 5'h00;
			hdr_reg     <= 11'h000;
			sh_reg      <= 16'h0000;
			reading_reg <= 1'b0;
			writing_reg <= 1'b0;
			acc         <= '0;
			mdio_out    <= 1'b0;
			mdio_oe     <= 1'b0;
		end
		else
		begin
			acc.rd <= 1'b0;
			acc.wr <= 1'b0;
			if (mdc_rise)
			begin
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
				case (state_reg)
				MDIO_IDLE:
				begin
					if (mdio_bit && pre_cnt_reg != `PNC_PRE_BITS)
						pre_cnt_reg <= pre_cnt_reg + 6'h01;
					else if (!mdio_bit)
					begin
						pre_cnt_reg <= 6'h00;
						if (pre_cnt_reg == `PNC_PRE_BITS)
							state_reg <= MDIO_START;
					end
				end
				MDIO_START:
				begin
					bit_cnt_reg <= 5'h00;
					state_reg   <= mdio_bit ? MDIO_HDR : MDIO_IDLE;
				end
				MDIO_HDR:
				begin
					hdr_reg <= hdr_full[10:0];
					if (bit_cnt_reg == `PNC_HDR_LAST)
					begin
						bit_cnt_reg <= 5'h00;
						state_reg   <= MDIO_TA;
						reading_reg <= phy_hit && op_rd;
						writing_reg <= phy_hit && op_wr;
						acc.rd      <= phy_hit && op_rd;
						acc.port    <= hdr_full[5];
						acc.regad   <= hdr_full[4:0];
					end
				end
				MDIO_TA:
				begin
					if (bit_cnt_reg == 5'h00)
					begin
						mdio_oe  <= reading_reg;
						mdio_out <= 1'b0;
					end
					else
					begin
						mdio_out    <= reading_reg & rd_data[15];
						sh_reg      <= {rd_data[14:0], 1'b0};
						bit_cnt_reg <= 5'h00;
						state_reg   <= MDIO_DATA;
					end
				end
				MDIO_DATA:
				begin
					if (reading_reg)
					begin
						mdio_out <= bit_last ? 1'b0 : sh_reg[15];
						mdio_oe  <= !bit_last;
						sh_reg   <= {sh_reg[14:0], 1'b0};
					end
					else
						sh_reg <= {sh_reg[14:0], mdio_bit};
					if (bit_last)
					begin
						acc.wr      <= writing_reg;
						acc.wdata   <= {sh_reg[14:0], mdio_bit};
						reading_reg <= 1'b0;
						writing_reg <= 1'b0;
						state_reg   <= MDIO_IDLE;
					end
				end
				default:
					state_reg <= MDIO_IDLE;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

/* File: rtl/pnc_phy_regs.sv */
/*
 * Dual-port next-page transmit, partner next-page receive and port
 * configuration registers behind the management serial interface.
 * Assumes management pins from outside the clock domain, and page,
 * mode and event inputs from auto-negotiation logic on clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pnc_regs.svh"

module pnc_phy_regs
	import pnc_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             mdc_pin,
	input  wire logic             mdio_in,
	output var  logic             mdio_out,
	output var  logic             mdio_oe,
	input  wire logic [1:0]       fiber_strap,
	input  wire pnc_mode_t [1:0]  port_mode,
	input  wire logic [1:0]       rx_page_load,
	input  wire logic [1:0][15:0] rx_page_data,
	input  wire logic [1:0]       tx_page_sent,
	input  wire logic [1:0]       page_rx_event,
	input  wire logic [1:0]       an_page_rx_var,
	output var  pnc_ctl_t [1:0]   port_ctl,
	output var  logic [1:0][15:0] tx_page,
	output var  logic [1:0]       page_received
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [2:0]       mdc_sync_reg;
	logic [2:0]       mdio_sync_reg;
	logic [1:0][2:0]  strap_sync_reg;
	logic             mdc_level_reg;
	logic             mdio_level_reg;
	logic             mdc_rise_reg;
	logic [1:0]       strap_level_reg;
	logic [2:0]       strap_wait_reg;

	wire logic mdc_agree  = (mdc_sync_reg[1] == mdc_sync_reg[2]);
	wire logic mdio_agree = (mdio_sync_reg[1] == mdio_sync_reg[2]);
	wire logic strap_load = (strap_wait_reg == 3'd1);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mdc_sync_reg   <= 3'h0;
			mdio_sync_reg  <= 3'h0;
			mdc_level_reg  <= 1'b0;
			mdio_level_reg <= 1'b0;
			mdc_rise_reg   <= 1'b0;
		end
		else
		begin
			mdc_sync_reg  <= {mdc_sync_reg[1:0], mdc_pin};
			mdio_sync_reg <= {mdio_sync_reg[1:0], mdio_in};
			if (mdc_agree)
				mdc_level_reg <= mdc_sync_reg[2];
			if (mdio_agree)
				mdio_level_reg <= mdio_sync_reg[2];
			mdc_rise_reg <= mdc_agree && mdc_sync_reg[2] && !mdc_level_reg;
		end
	end

	// Strap capture a few cycles after reset release
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			strap_sync_reg  <= '0;
			strap_level_reg <= 2'b00;
			strap_wait_reg  <= `PNC_STRAP_WAIT;
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				strap_sync_reg[p] <= {strap_sync_reg[p][1:0], fiber_strap[p]};
				if (strap_sync_reg[p][1] == strap_sync_reg[p][2])
					strap_level_reg[p] <= strap_sync_reg[p][2];
			end
			if (strap_wait_reg != 3'd0)
				strap_wait_reg <= strap_wait_reg - 3'd1;
		end
	end

	// ****************************************************************
	// Frame engine
	// ****************************************************************
	pnc_acc_t    acc;
	logic [15:0] rd_data_reg;

	pnc_mdio_engine u_engine (
		.clk      (clk),
		.rst_b    (rst_b),
		.mdc_rise (mdc_rise_reg),
		.mdio_bit (mdio_level_reg),
		.rd_data  (rd_data_reg),
		.acc      (acc),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe)
	);

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic acc_hit(input pnc_acc_t a, input logic port, input logic [4:0] regad);
		acc_hit = (a.port == port) && (a.regad == regad);
	endfunction

	function automatic pnc_ctl_t ctl_decode(input logic [15:0] cfg, input pnc_mode_t mode);
		logic ten;
		ten                     = !mode.speed_100;
		ctl_decode.link_force   = cfg[`PNC_CFG_LINK_FORCE];
		ctl_decode.tx_off       = cfg[`PNC_CFG_TX_OFF];
		ctl_decode.scr_bypass   = cfg[`PNC_CFG_SCR_BYP] && mode.speed_100;
		ctl_decode.code_bypass  = cfg[`PNC_CFG_CODE_BYP] && mode.speed_100;
		ctl_decode.jabber_off   = cfg[`PNC_CFG_JAB_OFF] && ten;
		ctl_decode.sqe_on       = cfg[`PNC_CFG_SQE_ON] && ten;
		ctl_decode.loopback_on  = !cfg[`PNC_CFG_LPBK_OFF] && ten && !mode.full_duplex;
		ctl_decode.crs_extend   = cfg[`PNC_CFG_CRS_EXT] && ten;
		ctl_decode.preamble_on  = cfg[`PNC_CFG_PRE_ON];
		ctl_decode.serial_10m   = cfg[`PNC_CFG_SER_10M] && ten;
		ctl_decode.fef_on       = cfg[`PNC_CFG_FEF_ON];
		ctl_decode.alt_np_on    = cfg[`PNC_CFG_ALT_NP];
		ctl_decode.fiber_on     = cfg[`PNC_CFG_FIBER];
	endfunction

	// ****************************************************************
	// Per-port registers
	// ****************************************************************
	logic [1:0][15:0] np_tx_reg;
	logic [1:0][15:0] np_rx_reg;
	logic [1:0][15:0] cfg_reg;
	logic [1:0]       pg_rx_reg;
	logic [1:0][15:0] np_tx_next;
	logic [1:0][15:0] cfg_next;
	logic [1:0]       pg_rx_next;
	logic [1:0]       wr_np_tx;
	logic [1:0]       wr_cfg;
	logic [1:0]       rd_exp;
	logic [1:0]       alt_clear;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gen_port
			assign wr_np_tx[g]  = acc.wr && acc_hit(acc, 1'(g), `PNC_REG_NP_TX);
			assign wr_cfg[g]    = acc.wr && acc_hit(acc, 1'(g), `PNC_REG_PORT_CFG);
			assign rd_exp[g]    = acc.rd && acc_hit(acc, 1'(g), `PNC_REG_AN_EXP);
			assign alt_clear[g] = cfg_reg[g][`PNC_CFG_ALT_NP]
				&& (!an_page_rx_var[g] || cfg_reg[g][`PNC_CFG_TX_OFF]);

			// Written value with hardware toggle flip on each sent page
			always_comb
			begin
				np_tx_next[g] = np_tx_reg[g];
				if (wr_np_tx[g])
					np_tx_next[g] = acc.wdata & `PNC_NP_TX_WMASK;
				if (tx_page_sent[g])
					np_tx_next[g][`PNC_NP_TOG] = !np_tx_reg[g][`PNC_NP_TOG];
			end

			always_comb
			begin
				cfg_next[g] = cfg_reg[g];
				if (wr_cfg[g])
					cfg_next[g] = acc.wdata;
				if (strap_load)
					cfg_next[g][`PNC_CFG_FIBER] = strap_level_reg[g];
			end

			// Event set wins over read and feature clears
			assign pg_rx_next[g] = page_rx_event[g]
				|| (pg_rx_reg[g] && !rd_exp[g] && !alt_clear[g]);

			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					np_tx_reg[g] <= `PNC_NP_TX_RST;
					np_rx_reg[g] <= `PNC_NP_RX_RST;
					cfg_reg[g]   <= `PNC_CFG_RST;
					pg_rx_reg[g] <= 1'b0;
				end
				else
				begin
					np_tx_reg[g] <= np_tx_next[g];
					cfg_reg[g]   <= cfg_next[g];
					pg_rx_reg[g] <= pg_rx_next[g];
					if (rx_page_load[g])
						np_rx_reg[g] <= rx_page_data[g];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Read data
	// ****************************************************************
	wire logic        rp = acc.port;
	wire logic [15:0] exp_word = {14'h0000, pg_rx_reg[rp], 1'b0};
	logic [15:0]      rd_sel;

	always_comb
	begin
		case (acc.regad)
		`PNC_REG_NP_TX:
			rd_sel = np_tx_reg[rp];
		`PNC_REG_NP_RX:
			rd_sel = np_rx_reg[rp];
		`PNC_REG_PORT_CFG:
			rd_sel = cfg_reg[rp];
		`PNC_REG_AN_EXP:
			rd_sel = exp_word;
		default:
			rd_sel = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rd_data_reg <= 16'h0000;
		else if (acc.rd)
			rd_data_reg <= rd_sel;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			port_ctl      <= '0;
			tx_page       <= '0;
			page_received <= 2'b00;
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				port_ctl[p] <= ctl_decode(cfg_reg[p], port_mode[p]);
				tx_page[p]  <= np_tx_reg[p];
			end
			page_received <= pg_rx_reg;
		end
	end

endmodule
`default_nettype wire

/* File: rtl/pnc_pkg.sv */
/*
 * Types shared by the register bank and its management frame engine.
 * Assumes the constants header is on the include path.
 */
`default_nettype none
package pnc_pkg;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        port;
		logic [4:0]  regad;
		logic [15:0] wdata;
	} pnc_acc_t;

	typedef struct packed {
		logic speed_100;
		logic full_duplex;
	} pnc_mode_t;

	typedef struct packed {
		logic link_force;
		logic tx_off;
		logic scr_bypass;
		logic code_bypass;
		logic jabber_off;
		logic sqe_on;
		logic loopback_on;
		logic crs_extend;
		logic preamble_on;
		logic serial_10m;
		logic fef_on;
		logic alt_np_on;
		logic fiber_on;
	} pnc_ctl_t;

	typedef enum logic [2:0] {
		MDIO_IDLE,
		MDIO_START,
		MDIO_HDR,
		MDIO_TA,
		MDIO_DATA
	} pnc_mdio_state_t;

endpackage
`default_nettype wire

/* File: rtl/pnc_regs.svh */
/*
 * Register offsets, field positions, reset values and counts for the
 * per-port next-page and port configuration register bank.
 * Assumes inclusion by the frame engine and register bank design files of this block.
 */
//
// Behaviour
// - Transmit message-type flag is writable and resets to one.
// - Transmit toggle resets to zero and reflects inverse of previous toggle.
// - Eleven-bit transmit code field is writable and resets to one.
// - Received partner page is read-only, more-pages flag shown, resets zero.
// - Receipt flag reads one once partner received our code word.
// - Received message-type, compliance and toggle bits reported read-only.
// - Link test disable forces link pass on status and indicators.
// - Transmit disable bit turns off twisted-pair transmitter; resets zero.
// - In 100 Mbit, bypass scrambler pair and 4B/5B coder separately.
// - In 10 Mbit, heartbeat enable bit and jabber disable bit.
// - 10 Mbit half-duplex loops transmit data back unless disabled.
// - Carrier-sense select extends CRS to RXDV deassertion; resets one.
// - Preamble bit chooses RXDV at SFD or at CRS with preamble.
// - Serial-mode bit drives 10 Mbit receive data on bit zero only.
// - Far-end fault transmission enable resets to one and gates sending.
// - Alternate next-page feature bit resets zero and enables modified handling.
// - Fiber select chooses fiber or twisted pair; loaded from pins at reset.
// - Sticky status bits hold until read, then clear on that read.
// - With alternate feature on, page-received also clears on variable false or disable.
//
`ifndef PNC_REGS_SVH
`define PNC_REGS_SVH

// ****************************************************************
// Offsets
// ****************************************************************
`define PNC_REG_AN_EXP      5'h06
`define PNC_REG_NP_TX       5'h07
`define PNC_REG_NP_RX       5'h08
`define PNC_REG_PORT_CFG    5'h10
`define PNC_PHY_BASE        5'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define PNC_NP_MORE         15
`define PNC_NP_ACK          14
`define PNC_NP_MSG          13
`define PNC_NP_CMPL         12
`define PNC_NP_TOG          11
`define PNC_AN_EXP_PAGE_RX  1
`define PNC_CFG_LINK_FORCE  14
`define PNC_CFG_TX_OFF      13
`define PNC_CFG_SCR_BYP     12
`define PNC_CFG_CODE_BYP    11
`define PNC_CFG_JAB_OFF     10
`define PNC_CFG_SQE_ON      9
`define PNC_CFG_LPBK_OFF    8
`define PNC_CFG_CRS_EXT     7
`define PNC_CFG_PRE_ON      5
`define PNC_CFG_SER_10M     3
`define PNC_CFG_FEF_ON      2
`define PNC_CFG_ALT_NP      1
`define PNC_CFG_FIBER       0

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define PNC_NP_TX_RST       16'h2001
`define PNC_NP_TX_WMASK     16'hbfff
`define PNC_NP_RX_RST       16'h0000
`define PNC_CFG_RST         16'h0084

// ****************************************************************
// Frame counts
// ****************************************************************
`define PNC_PRE_BITS        6'd32
`define PNC_HDR_LAST        5'd11
`define PNC_DATA_LAST       5'd15
`define PNC_STRAP_WAIT      3'd5

`endif

/* File: testbench/phy_next_page_and_port_config_tb.sv */
/*
 * Self-checking bench for the dual-port register bank.
 * Assumes the station model and the bound checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module phy_next_page_and_port_config_tb;
	import pnc_pkg::*;
	logic             clk;
	logic             rst_b;
	logic             mdc_pin;
	logic             mdio_d;
	logic             mdio_en;
	logic             mdio_out;
	logic             mdio_oe;
	wire logic        mdio_line;
	logic [1:0]       fiber_strap;
	pnc_mode_t [1:0]  port_mode;
	logic [1:0]       rx_page_load;
	logic [1:0][15:0] rx_page_data;
	logic [1:0]       tx_page_sent;
	logic [1:0]       page_rx_event;
	logic [1:0]       an_page_rx_var;
	pnc_ctl_t [1:0]   port_ctl;
	logic [1:0][15:0] tx_page;
	logic [1:0]       page_received;
	logic [15:0]      rdat;
	int               error_cnt;
	int               checks_done;

	assign mdio_line = mdio_oe ? mdio_out : (mdio_en ? mdio_d : 1'b1);

	pnc_station st_u (.clk(clk), .mdio_line(mdio_line), .mdc(mdc_pin), .mdio_d(mdio_d), .mdio_en(mdio_en));

	pnc_phy_regs dut_u (.clk(clk), .rst_b(rst_b), .mdc_pin(mdc_pin), .mdio_in(mdio_line), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .fiber_strap(fiber_strap), .port_mode(port_mode), .rx_page_load(rx_page_load),
		.rx_page_data(rx_page_data), .tx_page_sent(tx_page_sent), .page_rx_event(page_rx_event),
		.an_page_rx_var(an_page_rx_var), .port_ctl(port_ctl), .tx_page(tx_page), .page_received(page_received));

	always #2.5 clk = ~clk;

	// ****************
	// Shared tasks
	// ****************
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic rd(input logic port, input logic [4:0] regad);
		st_u.frame(2'b10, {4'h0, port}, regad, 16'h0000, rdat);
	endtask

	task automatic wr(input logic port, input logic [4:0] regad, input logic [15:0] wd);
		st_u.frame(2'b01, {4'h0, port}, regad, wd, rdat);
		tick(4);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		rd(1'b0, 5'h07);
		check("np tx p0", rdat, 16'h2001);
		rd(1'b0, 5'h08);
		check("np rx p0", rdat, 16'h0000);
		rd(1'b0, 5'h10);
		check("cfg p0", rdat, 16'h0085);
		rd(1'b1, 5'h10);
		check("cfg p1", rdat, 16'h0084);
		check("port ctl p1", {3'b000, port_ctl[1]}, 16'h0064);
		$display("test reset done");
	endtask

	task automatic t_np_tx();
		wr(1'b1, 5'h07, 16'hbfff);
		rd(1'b1, 5'h07);
		check("np tx p1", rdat, 16'hbfff);
		check("tx page p1", tx_page[1], 16'hbfff);
		check("tx page p0", tx_page[0], 16'h2001);
		@(posedge clk);
		tx_page_sent <= 2'b10;
		@(posedge clk);
		tx_page_sent <= 2'b00;
		tick(3);
		check("toggle p1", tx_page[1], 16'hb7ff);
		st_u.frame(2'b11, 5'h00, 5'h07, 16'h0000, rdat);
		tick(4);
		check("refused op", tx_page[0], 16'h2001);
		$display("test transmit page done");
	endtask

	task automatic t_np_rx();
		@(posedge clk);
		rx_page_data[0] <= 16'hd5a5;
		rx_page_load <= 2'b01;
		@(posedge clk);
		rx_page_load <= 2'b00;
		rd(1'b0, 5'h08);
		check("np rx p0", rdat, 16'hd5a5);
		wr(1'b0, 5'h08, 16'h0000);
		rd(1'b0, 5'h08);
		check("np rx ro", rdat, 16'hd5a5);
		rd(1'b1, 5'h08);
		check("np rx p1", rdat, 16'h0000);
		$display("test receive page done");
	endtask

	task automatic cfg_case(input logic [1:0] mode, input logic [15:0] wd, input logic [15:0] exp);
		@(posedge clk);
		port_mode[0] <= pnc_mode_t'(mode);
		wr(1'b0, 5'h10, wd);
		check("port ctl", {3'b000, port_ctl[0]}, exp);
	endtask

	task automatic t_cfg();
		cfg_case(2'b00, 16'h7faf, 16'h19bf);
		rd(1'b0, 5'h10);
		check("cfg rw", rdat, 16'h7faf);
		cfg_case(2'b11, 16'h7faf, 16'h1e17);
		cfg_case(2'b00, 16'h0000, 16'h0040);
		cfg_case(2'b01, 16'h0000, 16'h0000);
		$display("test configuration done");
	endtask

	task automatic t_sticky();
		@(posedge clk);
		port_mode[0] <= pnc_mode_t'(2'b00);
		wr(1'b0, 5'h10, 16'h0084);
		@(posedge clk);
		page_rx_event <= 2'b01;
		@(posedge clk);
		page_rx_event <= 2'b00;
		tick(40);
		check("sticky held", {14'h0000, page_received}, 16'h0001);
		rd(1'b0, 5'h06);
		check("expansion", rdat, 16'h0002);
		tick(4);
		check("sticky read", {14'h0000, page_received}, 16'h0000);
		@(posedge clk);
		page_rx_event <= 2'b01;
		@(posedge clk);
		page_rx_event <= 2'b00;
		wr(1'b0, 5'h10, 16'h0086);
		check("sticky alt", {14'h0000, page_received}, 16'h0001);
		@(posedge clk);
		an_page_rx_var <= 2'b10;
		tick(4);
		check("sticky var", {14'h0000, page_received}, 16'h0000);
		@(posedge clk);
		an_page_rx_var <= 2'b11;
		page_rx_event <= 2'b01;
		@(posedge clk);
		page_rx_event <= 2'b00;
		tick(4);
		check("sticky reset", {14'h0000, page_received}, 16'h0001);
		wr(1'b0, 5'h10, 16'h2086);
		check("sticky tx off", {14'h0000, page_received}, 16'h0000);
		$display("test sticky status done");
	endtask

	initial
	begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		final_report();
	end

	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		fiber_strap = 2'b01;
		port_mode = '0;
		rx_page_load = 2'b00;
		rx_page_data = '0;
		tx_page_sent = 2'b00;
		page_rx_event = 2'b00;
		an_page_rx_var = 2'b11;
		error_cnt = 0;
		checks_done = 0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		tick(8);
		t_reset();
		t_np_tx();
		t_np_rx();
		t_cfg();
		t_sticky();
		final_report();
	end
endmodule

bind pnc_phy_regs pnc_monitor mon_u (.clk(clk), .rst_b(rst_b), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
	.fiber_strap(fiber_strap), .port_mode(port_mode), .tx_page_sent(tx_page_sent),
	.page_rx_event(page_rx_event), .an_page_rx_var(an_page_rx_var), .port_ctl(port_ctl),
	.tx_page(tx_page), .page_received(page_received));

`default_nettype wire

/* File: testbench/pnc_monitor.sv */
/*
 * Checker on the register bank's outputs against its inputs.
 * Assumes a bind from the bench top and an MDC period of 17 clocks.
 */
`timescale 1ns/10ps
`default_nettype none

module pnc_monitor
	import pnc_pkg::*;
(
	input wire logic             clk,
	input wire logic             rst_b,
	input wire logic             mdio_out,
	input wire logic             mdio_oe,
	input wire logic [1:0]       fiber_strap,
	input wire pnc_mode_t [1:0]  port_mode,
	input wire logic [1:0]       tx_page_sent,
	input wire logic [1:0]       page_rx_event,
	input wire logic [1:0]       an_page_rx_var,
	input wire pnc_ctl_t [1:0]   port_ctl,
	input wire logic [1:0][15:0] tx_page,
	input wire logic [1:0]       page_received
);
	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	reset_tx_a: assert property ($rose(rst_b) |=> tx_page[0] == 16'h2001 && tx_page[1] == 16'h2001)
		else $error("transmit page reset value wrong");
	reset_cfg_a: assert property ($rose(rst_b) |=> port_ctl[0].fef_on && !port_ctl[0].tx_off && !port_ctl[0].alt_np_on)
		else $error("configuration reset value wrong");
	fiber_load_a: assert property ($rose(rst_b) |-> ##6 port_ctl[0].fiber_on == fiber_strap[0])
		else $error("fiber select not loaded from strap");
	toggle_flip_a: assert property (tx_page_sent[1] |-> ##2 tx_page[1][11] != $past(tx_page[1][11]))
		else $error("toggle did not invert");
	sticky_set_a: assert property (page_rx_event[0] |-> ##2 page_received[0])
		else $error("page received not set");
	alt_clear_a: assert property ((port_ctl[0].alt_np_on && !an_page_rx_var[0] && !page_rx_event[0]) [*2] |=> !page_received[0])
		else $error("page received not cleared by variable");
	fast_gate_a: assert property (port_mode[0].speed_100 [*3] |-> !(port_ctl[0].jabber_off || port_ctl[0].sqe_on || port_ctl[0].crs_extend || port_ctl[0].serial_10m))
		else $error("ten megabit control active at 100");
	slow_gate_a: assert property (!port_mode[0].speed_100 [*3] |-> !port_ctl[0].scr_bypass && !port_ctl[0].code_bypass)
		else $error("bypass active at ten megabit");
	full_loop_a: assert property (port_mode[0].full_duplex [*3] |-> !port_ctl[0].loopback_on)
		else $error("loopback in full duplex");
	read_ta_a: assert property ($rose(mdio_oe) |-> !mdio_out [*8])
		else $error("turnaround zero missing");

	cover property (page_rx_event[0] ##2 page_received[0]);
	cover property ($rose(mdio_oe));
	cover property (port_ctl[0].loopback_on);
endmodule

`default_nettype wire

/* File: testbench/pnc_station.sv */
/*
 * Management station model: sends whole frames on MDC and MDIO.
 * Assumes the bench resolves the shared data line with a pull-up.
 */
`timescale 1ns/10ps
`default_nettype none

module pnc_station
(
	input  wire logic clk,
	input  wire logic mdio_line,
	output var  logic mdc,
	output var  logic mdio_d,
	output var  logic mdio_en
);
	initial
	begin
		mdc = 1'b0;
		mdio_d = 1'b1;
		mdio_en = 1'b0;
	end

	// ****************
	// Frame task, MDC still between frames
	// ****************
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hffffffff, 2'b01, op, phy, regad, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 0; i < 64; i++)
		begin
			@(posedge clk);
			mdio_en <= !(op == 2'b10 && i >= 46);
			mdio_d <= bits[63 - i];
			repeat (8) @(posedge clk);
			mdc <= 1'b1;
			repeat (8) @(posedge clk);
			if (i >= 47 && i <= 62)
				rd[62 - i] = mdio_line;
			mdc <= 1'b0;
		end
		@(posedge clk);
		mdio_en <= 1'b0;
	endtask
endmodule

`default_nettype wire
